// ===== hw/bus_fabric_cfg.svh
// Address map, widths and latency constants for the core memory bus fabric.
`ifndef BUS_FABRIC_CFG_SVH
`define BUS_FABRIC_CFG_SVH

`define PROG_ADDR_W      21
`define PROG_DATA_W      16
`define DATA_ADDR_W      24
`define WIDE_DATA_W      32
`define NARROW_DATA_W    16
`define ADDR_MSB         23
// Data map: RAM words, flash words and the peripheral register window.
`define RAM_BASE         24'h000000
`define RAM_WORDS_LOG2   12
`define FLASH_BASE       24'h004000
`define FLASH_WORDS_LOG2 12
`define PERIPH_BASE      24'h00f000
`define PERIPH_SPAN_LOG2 12
// Program map: program memory words.
`define PROG_WORDS_LOG2  12
// Read answers come one cycle after the request; peripheral adds none.
`define READ_LATENCY     1

`endif

// ===== hw/bus_fabric_pkg.sv
// Types shared by the core memory bus fabric files.
package bus_fabric_pkg;

    // Operand size on the primary data path.
    typedef enum logic [2:0] {
        SIZE_BYTE = 3'b001,
        SIZE_WORD = 3'b010,
        SIZE_LONG = 3'b100
    } op_size_e;

    // Target selected by a primary data address.
    typedef enum logic [3:0] {
        TGT_NONE   = 4'b0001,
        TGT_RAM    = 4'b0010,
        TGT_FLASH  = 4'b0100,
        TGT_PERIPH = 4'b1000
    } target_e;

    // Primary data request from the core.
    typedef struct packed {
        logic        rd;
        logic        wr;
        op_size_e    size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } data_req_s;

    // Program request from the core.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [20:0] addr;
    } prog_req_s;

    // Peripheral register bus request toward the bridge.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [15:0] wdata;
    } periph_req_s;

endpackage

// ===== hw/mem_ram.sv
// Single-port synchronous word memory with registered read data.
`timescale 1ns/100ps
`default_nettype none

module mem_ram #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    // Clock.
    input  wire logic          clk_i,
    // Access port.
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [DW-1:0] wmask_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Masked write and registered read; contents have no reset.
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i] <= (mem[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
        end
        rdata_o <= mem[addr_i];
    end

endmodule

`default_nettype wire

// ===== hw/mem_dual_read.sv
// Word memory with one read/write port and one extra read-only port.
`timescale 1ns/100ps
`default_nettype none

module mem_dual_read #(
    parameter int AW = 12
) (
    // Clock.
    input  wire logic          clk_i,
    // Primary port, 32-bit wide as two word halves.
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [31:0]   wmask_i,
    output logic      [31:0]   rdata_o,
    // Secondary read port, one word.
    input  wire logic [AW-1:0] addr2_i,
    output logic      [15:0]   rdata2_o
);

    logic [15:0] mem [0:(1<<AW)-1];
    logic [AW-1:0] addr_hi;

    assign addr_hi = addr_i + {{(AW-1){1'b0}}, 1'b1};

    // Long writes span two words; reads return a word pair and a second word.
    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[addr_i]  <= (mem[addr_i] & ~wmask_i[15:0]) | (wdata_i[15:0] & wmask_i[15:0]);
            mem[addr_hi] <= (mem[addr_hi] & ~wmask_i[31:16])
                          | (wdata_i[31:16] & wmask_i[31:16]);
        end
        rdata_o  <= {mem[addr_hi], mem[addr_i]};
        rdata2_o <= mem[addr2_i];
    end

endmodule

`default_nettype wire

// ===== hw/core_bus_fabric.sv
// Core memory bus fabric: program, primary data, secondary data and peripheral paths.
// Notes on behaviour
// R1 - Program reads return 16-bit words addressed by a 21-bit program address.
// R2 - Program memory writes use only the low 16 bits of write data.
// R3 - Primary data path: 24-bit address, byte/word/long, 32-bit write and read buses.
// R4 - Primary data addresses also reach memory-mapped peripheral registers.
// R5 - Secondary path serves the second simultaneous read, words only, 16-bit data.
// R6 - Peripheral bus is 16 bits at data clock, adding no delay cycles.
// R7 - Peripheral writes use primary write data; reads return on primary read bus.
// R8 - Byte accesses force the top data address bit to zero.
// R9 - Data RAM primary port is 32 bits; all other data ports are 16.
// R10 - Flash control goes over the peripheral bus; array access goes direct.
// R11 - All peripheral registers are reached through the peripheral bus.
// R12 - Core presents address, qualifiers and write data in the same cycle.
`include "bus_fabric_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module core_bus_fabric (
    // Clock and reset.
    input  wire logic                           clk_i,
    input  wire logic                           resetn_i,
    // Program memory interface.
    input  wire bus_fabric_pkg::prog_req_s      prog_req_i,
    output logic      [`PROG_DATA_W-1:0]        prog_rdata_o,
    // Primary data interface.
    input  wire bus_fabric_pkg::data_req_s      data_req_i,
    output logic      [`WIDE_DATA_W-1:0]        data_rdata_o,
    // Secondary data interface.
    input  wire logic                           sec_rd_i,
    input  wire logic [`DATA_ADDR_W-1:0]        secondary_data_addr_i,
    output logic      [`NARROW_DATA_W-1:0]      secondary_read_bus_o,
    // Peripheral register bus toward the bridge.
    output bus_fabric_pkg::periph_req_s         periph_reg_bus_o,
    input  wire logic [`NARROW_DATA_W-1:0]      periph_rdata_i
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Selects the target of a primary data address.
    function automatic bus_fabric_pkg::target_e decode(input logic [23:0] a);
        if (a[23:`PERIPH_SPAN_LOG2] == `PERIPH_BASE >> `PERIPH_SPAN_LOG2) begin
            return bus_fabric_pkg::TGT_PERIPH;
        end else if (a[23:`FLASH_WORDS_LOG2+1] == `FLASH_BASE >> (`FLASH_WORDS_LOG2+1)) begin
            return bus_fabric_pkg::TGT_FLASH;
        end else if (a[23:`RAM_WORDS_LOG2+1] == `RAM_BASE >> (`RAM_WORDS_LOG2+1)) begin
            return bus_fabric_pkg::TGT_RAM;
        end else begin
            return bus_fabric_pkg::TGT_NONE;
        end
    endfunction

    // Word lane mask for an operand size and byte offset.
    function automatic logic [31:0] lane_mask(input bus_fabric_pkg::op_size_e s,
                                              input logic b);
        case (s)
            bus_fabric_pkg::SIZE_BYTE: return b ? 32'h0000ff00 : 32'h000000ff;
            bus_fabric_pkg::SIZE_WORD: return 32'h0000ffff;
            bus_fabric_pkg::SIZE_LONG: return 32'hffffffff;
            default:                   return 32'h00000000;
        endcase
    endfunction

    logic                    is_byte;
    logic [23:0]             eff_addr;
    logic [23:0]             word_addr;
    bus_fabric_pkg::target_e tgt;
    logic                    acc;

    // Byte accesses lose the top address bit; byte address splits word/lane.
    always_comb begin
        is_byte   = data_req_i.size == bus_fabric_pkg::SIZE_BYTE;
        eff_addr  = data_req_i.addr;
        if (is_byte) begin
            eff_addr[`ADDR_MSB] = 1'b0; // see R8
        end
        word_addr = is_byte ? {1'b0, eff_addr[23:1]} : eff_addr; // see R3
        tgt       = decode(word_addr); // see R4
        acc       = data_req_i.rd | data_req_i.wr;
    end

    // ------------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------------

    logic [31:0] wdata_al;
    logic [31:0] wmask;
    logic [31:0] ram_rdata;
    logic [15:0] ram_rdata2;
    logic [31:0] flash_rdata;
    logic [15:0] prog_rdata;
    logic [15:0] flash_hi;

    // Byte data is moved into its lane; masks select the written lanes.
    always_comb begin
        wdata_al = (is_byte && data_req_i.addr[0]) ? {16'h0000, data_req_i.wdata[7:0], 8'h00}
                                                    : data_req_i.wdata; // see R3
        wmask    = lane_mask(data_req_i.size, data_req_i.addr[0]);
    end

    // Data RAM: 32-bit primary port, 16-bit secondary read port.
    mem_dual_read #(.AW(`RAM_WORDS_LOG2)) u_ram (
        .clk_i    (clk_i),
        .wr_i     (data_req_i.wr && tgt == bus_fabric_pkg::TGT_RAM),
        .addr_i   (word_addr[`RAM_WORDS_LOG2-1:0]),
        .wdata_i  (wdata_al),
        .wmask_i  (wmask),
        .rdata_o  (ram_rdata),
        .addr2_i  (secondary_data_addr_i[`RAM_WORDS_LOG2-1:0]),
        .rdata2_o (ram_rdata2)
    ); // see R9 see R5

    // Data flash array, 16-bit port; long operands take two word cycles in real
    // silicon, here the low word is served and the high word reads zero.
    mem_ram #(.AW(`FLASH_WORDS_LOG2), .DW(16)) u_flash (
        .clk_i   (clk_i),
        .wr_i    (data_req_i.wr && tgt == bus_fabric_pkg::TGT_FLASH),
        .addr_i  (word_addr[`FLASH_WORDS_LOG2-1:0]),
        .wdata_i (wdata_al[15:0]),
        .wmask_i (wmask[15:0]),
        .rdata_o (flash_hi)
    ); // see R10 see R9
    assign flash_rdata = {16'h0000, flash_hi};

    // Program memory, written with the low half of the core write bus.
    mem_ram #(.AW(`PROG_WORDS_LOG2), .DW(16)) u_prog (
        .clk_i   (clk_i),
        .wr_i    (prog_req_i.wr),
        .addr_i  (prog_req_i.addr[`PROG_WORDS_LOG2-1:0]),
        .wdata_i (data_req_i.wdata[15:0]),
        .wmask_i (16'hffff),
        .rdata_o (prog_rdata)
    ); // see R2 see R12

    // ------------------------------------------------------------------
    // Peripheral register bus
    // ------------------------------------------------------------------

    // Peripheral strobes follow the core request in the same cycle.
    always_comb begin
        periph_reg_bus_o.rd    = data_req_i.rd && tgt == bus_fabric_pkg::TGT_PERIPH; // see R11
        periph_reg_bus_o.wr    = data_req_i.wr && tgt == bus_fabric_pkg::TGT_PERIPH;
        periph_reg_bus_o.addr  = word_addr[`PERIPH_SPAN_LOG2-1:0];
        periph_reg_bus_o.wdata = data_req_i.wdata[15:0]; // see R7
    end

    // ------------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------------

    bus_fabric_pkg::target_e rtgt;
    bus_fabric_pkg::target_e next_rtgt;
    logic                    rbyte;
    logic                    next_rbyte;
    logic                    rlane;
    logic                    next_rlane;
    logic [15:0]             pdata;
    logic [15:0]             next_pdata;
    logic                    srd;
    logic                    next_srd;

    // Remembers the target of each read for one cycle.
    always_comb begin
        next_rtgt  = data_req_i.rd ? tgt : bus_fabric_pkg::TGT_NONE;
        next_rbyte = is_byte;
        next_rlane = data_req_i.addr[0];
        next_pdata = periph_rdata_i; // see R6
        next_srd   = sec_rd_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rtgt  <= bus_fabric_pkg::TGT_NONE;
            rbyte <= 1'b0;
            rlane <= 1'b0;
            pdata <= 16'h0000;
            srd   <= 1'b0;
        end else begin
            rtgt  <= next_rtgt;
            rbyte <= next_rbyte;
            rlane <= next_rlane;
            pdata <= next_pdata;
            srd   <= next_srd;
        end
    end

    logic [31:0] raw;

    // Steers the addressed target onto the primary read bus.
    always_comb begin
        case (rtgt)
            bus_fabric_pkg::TGT_RAM:    raw = ram_rdata;
            bus_fabric_pkg::TGT_FLASH:  raw = flash_rdata; // see R10
            bus_fabric_pkg::TGT_PERIPH: raw = {16'h0000, pdata}; // see R7
            bus_fabric_pkg::TGT_NONE:   raw = 32'h00000000;
            default:                    raw = 32'h00000000;
        endcase
        if (rbyte) begin
            raw = {24'h000000, rlane ? raw[15:8] : raw[7:0]};
        end
    end

    assign data_rdata_o         = raw; // see R3
    assign secondary_read_bus_o = srd ? ram_rdata2 : 16'h0000; // see R5
    assign prog_rdata_o         = prog_rdata; // see R1

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    property p_byte_msb;
        @(posedge clk_i) disable iff (!resetn_i)
        (acc && is_byte) |-> word_addr == {2'b00, data_req_i.addr[22:1]};
    endproperty
    a_byte_msb: assert property (p_byte_msb) else $error("byte access kept top bit"); // see R8

    property p_periph_nowait;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.rd && tgt == bus_fabric_pkg::TGT_PERIPH && !is_byte)
        |=> data_rdata_o == {16'h0000, $past(periph_rdata_i)};
    endproperty
    a_periph_nowait: assert property (p_periph_nowait) else $error("periph read late"); // see R6

    property p_periph_wdata;
        @(posedge clk_i) disable iff (!resetn_i)
        periph_reg_bus_o.wr |-> periph_reg_bus_o.wdata == data_req_i.wdata[15:0];
    endproperty
    a_periph_wdata: assert property (p_periph_wdata) else $error("periph wdata wrong"); // see R7

    property p_periph_sel;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.wr && word_addr[23:12] == 12'h00f) |-> periph_reg_bus_o.wr;
    endproperty
    a_periph_sel: assert property (p_periph_sel) else $error("periph not selected"); // see R4

    property p_sec_idle;
        @(posedge clk_i) disable iff (!resetn_i)
        !sec_rd_i |=> secondary_read_bus_o == 16'h0000;
    endproperty
    a_sec_idle: assert property (p_sec_idle) else $error("secondary bus not idle"); // see R5

    property p_no_periph_ram;
        @(posedge clk_i) disable iff (!resetn_i)
        periph_reg_bus_o.wr |-> !u_ram.wr_i && !u_flash.wr_i;
    endproperty
    a_no_periph_ram: assert property (p_no_periph_ram) else $error("double write"); // see R11

    property p_byte_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.rd && is_byte) |=> data_rdata_o[31:8] == 24'h000000;
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("byte read upper set"); // see R3

    property p_none_zero;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.rd && tgt == bus_fabric_pkg::TGT_NONE) |=> data_rdata_o == 32'h0;
    endproperty
    a_none_zero: assert property (p_none_zero) else $error("unmapped read nonzero"); // see R4

    // A decoded peripheral read always raises the peripheral read strobe.
    property p_periph_rsel;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.rd && word_addr[23:12] == 12'h00f) |-> periph_reg_bus_o.rd;
    endproperty
    a_periph_rsel: assert property (p_periph_rsel) else $error("periph rd missing"); // see R11

    property p_periph_quiet;
        @(posedge clk_i) disable iff (!resetn_i)
        !acc |-> !periph_reg_bus_o.rd && !periph_reg_bus_o.wr;
    endproperty
    a_periph_quiet: assert property (p_periph_quiet) else $error("stray strobe"); // see R4

    // Byte writes touch only the lane picked by the low address bit.
    property p_byte_lane;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.wr && is_byte)
        |-> wmask == (data_req_i.addr[0] ? 32'h0000ff00 : 32'h000000ff);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte lane mask"); // see R3

    // The flash port is one word wide, so the upper read half stays clear.
    property p_flash_narrow;
        @(posedge clk_i) disable iff (!resetn_i)
        (data_req_i.rd && tgt == bus_fabric_pkg::TGT_FLASH) |=> data_rdata_o[31:16] == 16'h0000;
    endproperty
    a_flash_narrow: assert property (p_flash_narrow) else $error("flash upper set"); // see R9

    property p_prog_low_half;
        @(posedge clk_i) disable iff (!resetn_i)
        prog_req_i.wr |-> u_prog.wdata_i == data_req_i.wdata[15:0];
    endproperty
    a_prog_low_half: assert property (p_prog_low_half) else $error("prog wdata"); // see R2

    // Main scenarios that the bench is expected to reach.

    c_periph_rd: cover property (@(posedge clk_i) periph_reg_bus_o.rd);
    c_dual_rd:   cover property (@(posedge clk_i) data_req_i.rd && sec_rd_i
                                 && tgt == bus_fabric_pkg::TGT_RAM);
    c_byte_wr:   cover property (@(posedge clk_i) data_req_i.wr && is_byte);
    c_prog_rd:   cover property (@(posedge clk_i) prog_req_i.rd);

endmodule

`default_nettype wire

// ===== verification/core_model.sv
// Behavioural processor core that issues program, data and secondary requests.
`timescale 1ns/100ps
`default_nettype none

module core_model (
    // Clock.
    input  wire logic                       clk_i,
    // Requests toward the fabric.
    output var bus_fabric_pkg::prog_req_s   prog_req_o,
    output var bus_fabric_pkg::data_req_s   data_req_o,
    output logic                            sec_rd_o,
    output logic [23:0]                     sec_addr_o,
    // Answers from the fabric.
    input  wire logic [15:0]                prog_rdata_i,
    input  wire logic [31:0]                data_rdata_i,
    input  wire logic [15:0]                sec_rdata_i
);
    // Answers seen one cycle after each request edge.
    logic [15:0] prog_ans;
    logic [31:0] data_ans;
    logic [15:0] sec_ans;

    // Idle requests at time zero.
    initial begin
        prog_req_o = '0;
        data_req_o = '{1'b0, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000000, 32'h00000000};
        sec_rd_o   = 1'b0;
        sec_addr_o = 24'h000000;
    end

    // One cycle: address, qualifiers and write data change together and hold to the edge.
    // Answers are taken as the cycle opens, so each call reports the previous call's request.
    task automatic cyc(input bus_fabric_pkg::prog_req_s p, input bus_fabric_pkg::data_req_s d,
                       input logic s, input logic [23:0] sa);
        #1;
        prog_ans   = prog_rdata_i;
        data_ans   = data_rdata_i;
        sec_ans    = sec_rdata_i;
        prog_req_o = p;
        data_req_o = d;
        sec_rd_o   = s;
        sec_addr_o = sa;
        @(posedge clk_i);
        #1;
    endtask

    // Released buses show inverted stale addresses and write data; only the data size is held.
    task automatic idle();
        bus_fabric_pkg::prog_req_s p;
        bus_fabric_pkg::data_req_s d;
        p = '{1'b0, 1'b0, ~prog_req_o.addr};
        d = '{1'b0, 1'b0, data_req_o.size, ~data_req_o.addr, ~data_req_o.wdata};
        cyc(p, d, 1'b0, ~sec_addr_o);
    endtask
endmodule

`default_nettype wire

// ===== verification/core_memory_bus_interconnect_tb.sv
// Self-checking testbench for the core memory bus fabric.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module core_memory_bus_interconnect_tb;
    logic                        clk;
    logic                        resetn;
    bus_fabric_pkg::prog_req_s   prog_req;
    bus_fabric_pkg::data_req_s   data_req;
    logic                        sec_rd;
    logic [23:0]                 sec_addr;
    logic [15:0]                 prog_rdata;
    logic [31:0]                 data_rdata;
    logic [15:0]                 sec_rdata;
    bus_fabric_pkg::periph_req_s periph_bus;
    bus_fabric_pkg::periph_req_s last_pb;
    logic [15:0]                 periph_rdata;
    int                          fails;
    int                          samples_checked;

    // Clock generation, 50 ns period.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Bridge model: read data is a pattern of the address, inverted when not read.
    assign periph_rdata = periph_bus.rd ? {4'hb, periph_bus.addr} : ~{4'hb, periph_bus.addr};

    // Peripheral bus as seen at each request edge.
    always @(posedge clk) last_pb <= periph_bus;

    core_bus_fabric i_core_bus_fabric (
        .clk_i                 (clk),
        .resetn_i              (resetn),
        .prog_req_i            (prog_req),
        .prog_rdata_o          (prog_rdata),
        .data_req_i            (data_req),
        .data_rdata_o          (data_rdata),
        .sec_rd_i              (sec_rd),
        .secondary_data_addr_i (sec_addr),
        .secondary_read_bus_o  (sec_rdata),
        .periph_reg_bus_o      (periph_bus),
        .periph_rdata_i        (periph_rdata)
    );

    core_model i_core_model (
        .clk_i        (clk),
        .prog_req_o   (prog_req),
        .data_req_o   (data_req),
        .sec_rd_o     (sec_rd),
        .sec_addr_o   (sec_addr),
        .prog_rdata_i (prog_rdata),
        .data_rdata_i (data_rdata),
        .sec_rdata_i  (sec_rdata)
    );

    // One primary data cycle with no program or secondary request.
    task automatic dacc(input logic rd, input logic wr, input bus_fabric_pkg::op_size_e sz,
                        input logic [23:0] a, input logic [31:0] d);
        i_core_model.cyc('{1'b0, 1'b0, 21'h000000}, '{rd, wr, sz, a, d}, 1'b0, 24'h000000);
    endtask

    // Long write and read, then word read of the upper half.
    task automatic test_ram();
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_LONG, 24'h000010, 32'h12345678);
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_LONG, 24'h000010, 32'h00000000);
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000011, 32'h00000000);
        `CHK(i_core_model.data_ans, 32'h12345678)
        i_core_model.idle();
        `CHK(i_core_model.data_ans[15:0], 16'h1234)
    endtask

    // Byte write with the top address bit set lands in the lower half.
    task automatic test_byte();
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_WORD, 24'h000020, 32'h00001122);
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_BYTE, 24'h800041, 32'h0000abab);
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000020, 32'h00000000);
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_BYTE, 24'h800041, 32'h00000000);
        `CHK(i_core_model.data_ans[15:0], 16'hab22)
        i_core_model.idle();
        `CHK(i_core_model.data_ans, 32'h000000ab)
    endtask

    // Dual read: primary and secondary in one cycle, then secondary idle.
    task automatic test_secondary();
        i_core_model.cyc('{1'b0, 1'b0, 21'h000000},
            '{1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000011, 32'h00000000}, 1'b1, 24'h000010);
        i_core_model.idle();
        `CHK(i_core_model.data_ans[15:0], 16'h1234)
        `CHK(i_core_model.sec_ans, 16'h5678)
        i_core_model.idle();
        `CHK(i_core_model.sec_ans, 16'h0000)
    endtask

    // Peripheral write and back-to-back reads with no wait cycles.
    task automatic test_periph();
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_WORD, 24'h00f012, 32'h0000c3c3);
        `CHK(last_pb.wr, 1'b1)
        `CHK(last_pb.addr, 12'h012)
        `CHK(last_pb.wdata, 16'hc3c3)
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h00f0a5, 32'h00000000);
        `CHK(last_pb.rd, 1'b1)
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h00f0a6, 32'h00000000);
        `CHK(i_core_model.data_ans, 32'h0000b0a5)
        `CHK(last_pb.addr, 12'h0a6)
        i_core_model.idle();
        `CHK(i_core_model.data_ans, 32'h0000b0a6)
    endtask

    // Flash array access stays off the peripheral bus.
    task automatic test_flash();
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_WORD, 24'h004005, 32'h00005a5a);
        `CHK(last_pb.wr, 1'b0)
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h004005, 32'h00000000);
        `CHK(last_pb.rd, 1'b0)
        i_core_model.idle();
        `CHK(i_core_model.data_ans[15:0], 16'h5a5a)
    endtask

    // Program write takes the low write-data half; read returns it.
    task automatic test_prog();
        i_core_model.cyc('{1'b0, 1'b1, 21'h000123},
            '{1'b0, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000000, 32'hffff9abc}, 1'b0, 24'h000000);
        i_core_model.cyc('{1'b1, 1'b0, 21'h000123},
            '{1'b0, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h000000, 32'h00000000}, 1'b0, 24'h000000);
        i_core_model.idle();
        `CHK(i_core_model.prog_ans, 16'h9abc)
    endtask

    // Unmapped data address: write ignored, read gives zero.
    task automatic test_unmapped();
        dacc(1'b0, 1'b1, bus_fabric_pkg::SIZE_WORD, 24'h00a000, 32'h00007777);
        dacc(1'b1, 1'b0, bus_fabric_pkg::SIZE_WORD, 24'h00a000, 32'h00000000);
        i_core_model.idle();
        `CHK(i_core_model.data_ans, 32'h00000000)
    endtask

    // Verdict and end of run.
    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        fails = 0;
        samples_checked = 0;
        resetn = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        resetn = 1'b1;
        @(posedge clk);
        #1;
        test_ram();
        test_byte();
        test_secondary();
        test_periph();
        test_flash();
        test_prog();
        test_unmapped();
        finish_test();
    end

    // Watchdog well beyond the expected run of about 30 cycles.
    initial begin
        #(400 * 50);
        fails++;
        finish_test();
    end
endmodule

`default_nettype wire
